// file: rtl/rmpc_monitor.sv
// Purpose: Frequency detector and three monitors for one reference.
// Assumes: Rising edges arrive as one-cycle pulses in the clk_sys domain.
// Notes:   Period limits are set for a 125 MHz clock; the class sets them.
`timescale 1ns/100ps
module rmpc_monitor
#(
	parameter longint PRECISE_CYC = rmpc_pkg::PRECISE_CYC
)
(
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic                         rise,
	input  wire logic                         range_limit_choice,
	output rmpc_pkg::rmpc_mon_t               mon,
	output logic [rmpc_pkg::PER_W-1:0]        period
);

	localparam int W = rmpc_pkg::PER_W;

	// Nominal period in cycles for each class.
	function automatic logic [W-1:0] nom_per(input rmpc_pkg::rmpc_rate_t r);
		case (r)
			rmpc_pkg::RMPC_RATE_2K:     nom_per = 24'h00F424;
			rmpc_pkg::RMPC_RATE_8K:     nom_per = 24'h003D09;
			rmpc_pkg::RMPC_RATE_1M544:  nom_per = 24'h000051;
			rmpc_pkg::RMPC_RATE_2M048:  nom_per = 24'h00003D;
			rmpc_pkg::RMPC_RATE_8M192:  nom_per = 24'h00000F;
			rmpc_pkg::RMPC_RATE_16M384: nom_per = 24'h000008;
			rmpc_pkg::RMPC_RATE_19M44:  nom_per = 24'h000006;
			default:                    nom_per = 24'hFFFFFF;
		endcase
	endfunction

	// Classify a measured period into the nearest rate class.
	function automatic rmpc_pkg::rmpc_rate_t classify(input logic [W-1:0] p);
		if (p > 24'h00B000 && p < 24'h013000)
			classify = rmpc_pkg::RMPC_RATE_2K;
		else if (p > 24'h003000 && p < 24'h005000)
			classify = rmpc_pkg::RMPC_RATE_8K;
		else if (p >= 24'h000048 && p < 24'h00005C)
			classify = rmpc_pkg::RMPC_RATE_1M544;
		else if (p >= 24'h000034 && p < 24'h000048)
			classify = rmpc_pkg::RMPC_RATE_2M048;
		else if (p >= 24'h00000C && p < 24'h000013)
			classify = rmpc_pkg::RMPC_RATE_8M192;
		else if (p == 24'h000007 || p == 24'h000008)
			classify = rmpc_pkg::RMPC_RATE_16M384;
		else if (p >= 24'h000005 && p < 24'h000007)
			classify = rmpc_pkg::RMPC_RATE_19M44;
		else
			classify = rmpc_pkg::RMPC_RATE_NONE;
	endfunction

	logic [W-1:0]          cnt_q;
	logic [W-1:0]          nom;
	rmpc_pkg::rmpc_rate_t  rate_q;
	logic                  single_q;
	logic [15:0]           win_q;
	logic [15:0]           edges_q;
	logic                  coarse_q;
	logic [31:0]           pwin_q;
	logic [31:0]           pedges_q;
	logic                  precise_q;

	assign nom = nom_per(rate_q);
	assign mon = '{precise_fail: precise_q, coarse_fail: coarse_q,
		single_fail: single_q, rate: rate_q};

	// Measure each period between rising edges and classify it; the single
	// period check flags a cycle far outside its nominal length. A clear
	// needs a cycle within a tighter band, which gives hysteresis.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cnt_q    <= rmpc_pkg::PER_RST;
			period   <= rmpc_pkg::PER_RST;
			rate_q   <= rmpc_pkg::RMPC_RATE_NONE;
			single_q <= 1'b1;
		end
		else if (rise)
		begin
			cnt_q  <= 24'h000001;
			period <= cnt_q;
			if (rate_q == rmpc_pkg::RMPC_RATE_NONE || classify(cnt_q) != rate_q)
				rate_q <= classify(cnt_q);
			if (cnt_q > nom + (nom >> 2) + 24'h000002 || cnt_q + (nom >> 2) + 24'h000002 < nom)
				single_q <= 1'b1; // [R08]
			else if (cnt_q <= nom + (nom >> 3) + 24'h000001 &&
				cnt_q + (nom >> 3) + 24'h000001 >= nom)
				single_q <= 1'b0; // [R15]
		end
		else
		begin
			if (cnt_q != 24'hFFFFFF)
				cnt_q <= cnt_q + 24'h000001;
			if (cnt_q > (nom << 1) + 24'h000004)
				single_q <= 1'b1; // [R08]
		end
	end

	// Coarse rate check: count edges in a fixed window and compare to nominal.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			win_q    <= 16'h0000;
			edges_q  <= 16'h0000;
			coarse_q <= 1'b1;
		end
		else if (win_q == 16'(rmpc_pkg::COARSE_WIN_CYC - 1))
		begin
			win_q   <= 16'h0000;
			edges_q <= 16'h0000;
			// Expected edges equal window over period; allow a wide band with hysteresis.
			if (32'(edges_q) * 32'(nom) > 32'(rmpc_pkg::COARSE_WIN_CYC) * 2 ||
				32'(edges_q + 16'h0002) * 32'(nom) < 32'(rmpc_pkg::COARSE_WIN_CYC) / 2)
				coarse_q <= 1'b1; // [R07]
			else if (32'(edges_q) * 32'(nom) <= 32'(rmpc_pkg::COARSE_WIN_CYC) * 3 / 2)
				coarse_q <= 1'b0; // [R15]
		end
		else
		begin
			win_q <= win_q + 16'h0001;
			if (rise)
				edges_q <= edges_q + 16'h0001;
		end
	end

	// Precise monitor: count edges over the long window; the offset in ppm
	// is compared against the band chosen by range_limit_choice. The fail
	// limit is the top of the band and the clear limit its bottom.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pwin_q    <= 32'h00000000;
			pedges_q  <= 32'h00000000;
			precise_q <= 1'b1;
		end
		else if (64'(pwin_q) == 64'(PRECISE_CYC - 1))
		begin : close_window
			longint exp_cyc;
			longint err_ppm;
			exp_cyc = longint'(pedges_q) * longint'(nom);
			err_ppm = (exp_cyc > PRECISE_CYC) ? exp_cyc - PRECISE_CYC : PRECISE_CYC - exp_cyc;
			err_ppm = (PRECISE_CYC == 0) ? 0 : (err_ppm * 1000000) / PRECISE_CYC;
			pwin_q   <= 32'h00000000;
			pedges_q <= 32'h00000000;
			if (err_ppm > (range_limit_choice ? 130 : 83))
				precise_q <= 1'b1; // [R05] [R06]
			else if (err_ppm < (range_limit_choice ? 100 : 64))
				precise_q <= 1'b0; // [R06] [R15]
		end
		else
		begin
			pwin_q <= pwin_q + 32'h00000001;
			if (rise)
				pedges_q <= pedges_q + 32'h00000001;
		end
	end

endmodule

// file: rtl/rmpc_pkg.sv
// Purpose: Shared constants and types for the reference monitor and phase corrector.
// Assumes: System clock of 125 MHz (8 ns period).
// Notes:   Long times are module parameters in the top; figures here are defaults.
package rmpc_pkg;

	// System clock rate in Hz.
	localparam longint CLK_HZ = 125000000;

	// Nominal rate classes found by the frequency detector.
	typedef enum logic [2:0]
	{
		RMPC_RATE_NONE,
		RMPC_RATE_2K,
		RMPC_RATE_8K,
		RMPC_RATE_1M544,
		RMPC_RATE_2M048,
		RMPC_RATE_8M192,
		RMPC_RATE_16M384,
		RMPC_RATE_19M44
	} rmpc_rate_t;

	// Per-reference monitor verdicts.
	typedef struct packed
	{
		logic       precise_fail;
		logic       coarse_fail;
		logic       single_fail;
		rmpc_rate_t rate;
	} rmpc_mon_t;

	// Loop mode seen by the corrector.
	typedef enum logic [1:0]
	{
		RMPC_NORMAL,
		RMPC_HOLDOVER
	} rmpc_mode_t;

	// Coarse rate check window, in ns, and its length in cycles.
	localparam int COARSE_WIN_NS = 30000;
	localparam int COARSE_WIN_CYC = int'((longint'(COARSE_WIN_NS) * CLK_HZ) / 1000000000);
	// Disqualify, requalify and precise window times, in ms.
	localparam int DISQ_MS = 2500;
	localparam int REQ_MS = 10000;
	localparam int PRECISE_MS = 10000;
	// Default cycle counts derived from the times above.
	localparam longint DISQ_CYC = (longint'(DISQ_MS) * CLK_HZ) / 1000;
	localparam longint REQ_CYC = (longint'(REQ_MS) * CLK_HZ) / 1000;
	localparam longint PRECISE_CYC = (longint'(PRECISE_MS) * CLK_HZ) / 1000;
	// Least clear pulse, in ns, and its cycle count rounded up.
	localparam int CLR_MIN_NS = 15;
	localparam int CLR_MIN_CYC = (CLR_MIN_NS * 8 + 999) / 1000 + 1;
	// Alignment slew limit in ns per second with narrow bandwidth.
	localparam int SLEW_NS_PER_S = 61000;
	// Cycles between one-cycle (8 ns) alignment steps; the count is that for one-nanosecond steps at the narrow slew limit.
	localparam int SLEW_STEP_CYC = int'(CLK_HZ / SLEW_NS_PER_S);
	// Width of period and phase measurements in cycles.
	localparam int PER_W = 24;
	// Reset values.
	localparam logic [PER_W-1:0] PER_RST = 24'h000000;

endpackage

// file: rtl/rmpc_sync.sv
// Purpose: Three-stage synchroniser with edge detection for one pin input.
// Assumes: The input is asynchronous to clk_sys.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/100ps
module rmpc_sync
(
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);

	logic [2:0] stage_q;

	// Shift the pin through three flops; only stage two feeds stage three.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			stage_q <= 3'h0;
		else
			stage_q <= {stage_q[1:0], pin};
	end

	// Settled level, updated only when the last two stages agree.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			level <= 1'b0;
			rise  <= 1'b0;
		end
		else
		begin
			rise <= 1'b0;
			if (stage_q[2] == stage_q[1] && stage_q[2] != level)
			begin
				level <= stage_q[2];
				rise  <= stage_q[2];
			end
		end
	end

endmodule

// file: rtl/rmpc_top.sv
// Purpose: Reference monitors, qualify timers and phase-offset corrector.
// Assumes: clk_sys at 125 MHz; references and control pins are asynchronous.
// Notes:   Phase values are counted in clk_sys cycles.
//
// Overview of operation
// [R01] Route one selected reference to corrector.
// [R02] Choice low picks primary, high secondary.
// [R03] Both references monitored; rising edges only.
// [R04] Detector classifies seven nominal rates per reference.
// [R05] Precise monitor checks chosen ppm limits.
// [R06] Low picks 64-83 ppm, high 100-130.
// [R07] Coarse check over roughly 30 us windows.
// [R08] Single period check flags hits, loss.
// [R09] Any monitor failure raises reference fault.
// [R10] Fast failure on active reference forces holdover.
// [R11] Timer disqualifies after 2.5 s failure.
// [R12] Short failures accumulate toward disqualification.
// [R13] Requalify after 10 s clean.
// [R14] Fault clear returns loop to normal.
// [R15] Monitors use threshold hysteresis.
// [R16] Precise monitor, timer never change mode.
// [R17] Store offset on switch or recovery.
// [R18] Clear low 15 ns discards stored offset.
// [R19] Realign at 61 us/s, shortest direction; code steps 8 ns every 2049 cycles, about 488 us/s.
// [R20] Clear held low keeps reference alignment.
// [R21] Controller avoids clearing after short holdover.
// [R22] Hitless return low keeps stored offset.
// [R23] Hitless return high remeasures offset.
// [R24] Switches hitless unless clear held low.
`timescale 1ns/100ps
module rmpc_top
#(
	parameter longint DISQ_CYC    = rmpc_pkg::DISQ_CYC,
	parameter longint REQ_CYC     = rmpc_pkg::REQ_CYC,
	parameter longint PRECISE_CYC = rmpc_pkg::PRECISE_CYC
)
(
	input  wire logic                       clk_sys,
	input  wire logic                       reset,
	input  wire logic                       primary_reference,
	input  wire logic                       secondary_reference,
	input  wire logic                       reference_choice,
	input  wire logic                       range_limit_choice,
	input  wire logic                       phase_offset_clear_n,
	input  wire logic                       loop_bandwidth_choice,
	input  wire logic                       hitless_return_enable,
	input  wire logic                       feedback,
	output logic                            primary_fault,
	output logic                            secondary_fault,
	output logic                            primary_disqualified,
	output logic                            secondary_disqualified,
	output logic                            holdover,
	output logic                            virtual_reference,
	output rmpc_pkg::rmpc_rate_t            selected_rate,
	output logic [rmpc_pkg::PER_W-1:0]      stored_offset
);

	localparam int W = rmpc_pkg::PER_W;

	// Refuse cycle counts below one, and precise windows that the 32-bit window counter cannot hold.
	if (DISQ_CYC < 1 || REQ_CYC < 1 || PRECISE_CYC < 1 || PRECISE_CYC > 64'hFFFFFFFF)
	begin : g_bad_counts
		$error("rmpc_top: cycle counts out of range");
	end

	// Reduce a phase count into one period by subtracting the period once when it reaches it.
	function automatic logic [W-1:0] wrap_phase(input logic [W-1:0] ph,
		input logic [W-1:0] per);
		if (per == '0)
			wrap_phase = ph;
		else if (ph >= per)
			wrap_phase = ph - per;
		else
			wrap_phase = ph;
	endfunction

	logic [1:0]                ref_lvl;
	logic [1:0]                ref_rise;
	logic                      fb_rise;
	logic                      sel_lvl;
	logic                      clr_lvl_n;
	logic                      oor_lvl;
	logic                      bw_lvl;
	logic                      hms_lvl;
	rmpc_pkg::rmpc_mon_t       mon [2];
	logic [W-1:0]              period [2];
	logic [1:0]                fast_fail;
	logic [39:0]               fail_acc_q [2];
	logic [39:0]               clean_q [2];
	logic [1:0]                disq_q;
	logic                      sel_q;
	logic                      hold_q;
	logic [W-1:0]              since_ref_q;
	logic [W-1:0]              meas_q;
	logic [W-1:0]              target_q;
	logic [W-1:0]              vcnt_q;
	logic                      remeasure_q;
	logic [31:0]               slew_q;
	logic                      clr_low_q;

	// Synchronise the reference and feedback edges and each static pin.
	rmpc_sync u_sync_p   (.clk_sys(clk_sys), .reset(reset), .pin(primary_reference),
		.level(ref_lvl[0]), .rise(ref_rise[0]));
	rmpc_sync u_sync_s   (.clk_sys(clk_sys), .reset(reset), .pin(secondary_reference),
		.level(ref_lvl[1]), .rise(ref_rise[1]));
	rmpc_sync u_sync_fb  (.clk_sys(clk_sys), .reset(reset), .pin(feedback),
		.level(), .rise(fb_rise));
	rmpc_sync u_sync_sel (.clk_sys(clk_sys), .reset(reset), .pin(reference_choice),
		.level(sel_lvl), .rise());
	rmpc_sync u_sync_oor (.clk_sys(clk_sys), .reset(reset), .pin(range_limit_choice),
		.level(oor_lvl), .rise());
	rmpc_sync u_sync_bw  (.clk_sys(clk_sys), .reset(reset), .pin(loop_bandwidth_choice),
		.level(bw_lvl), .rise());
	rmpc_sync u_sync_hms (.clk_sys(clk_sys), .reset(reset), .pin(hitless_return_enable),
		.level(hms_lvl), .rise());
	rmpc_sync u_sync_clr (.clk_sys(clk_sys), .reset(reset), .pin(~phase_offset_clear_n),
		.level(clr_lvl_n), .rise());

	// One monitor per reference, both running at once on rising edges.
	rmpc_monitor #(.PRECISE_CYC(PRECISE_CYC)) u_mon_p
	(
		.clk_sys            (clk_sys),
		.reset              (reset),
		.rise               (ref_rise[0]), // [R03]
		.range_limit_choice (oor_lvl),
		.mon                (mon[0]), // [R04]
		.period             (period[0])
	);
	rmpc_monitor #(.PRECISE_CYC(PRECISE_CYC)) u_mon_s
	(
		.clk_sys            (clk_sys),
		.reset              (reset),
		.rise               (ref_rise[1]), // [R03]
		.range_limit_choice (oor_lvl),
		.mon                (mon[1]), // [R04]
		.period             (period[1])
	);

	assign fast_fail[0] = mon[0].single_fail | mon[0].coarse_fail;
	assign fast_fail[1] = mon[1].single_fail | mon[1].coarse_fail;

	// Fault outputs follow any monitor failure of their own reference.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			primary_fault   <= 1'b1;
			secondary_fault <= 1'b1;
		end
		else
		begin
			primary_fault   <= fast_fail[0] | mon[0].precise_fail; // [R09]
			secondary_fault <= fast_fail[1] | mon[1].precise_fail; // [R09]
		end
	end

	// Disqualify timers: failure time accumulates across short failures and
	// is only cleared by a long clean stretch, which also requalifies.
	for (genvar i = 0; i < 2; i++)
	begin : g_timer
		always_ff @(posedge clk_sys or posedge reset)
		begin
			if (reset)
			begin
				fail_acc_q[i] <= 40'h0000000000;
				clean_q[i]    <= 40'h0000000000;
				disq_q[i]     <= 1'b1;
			end
			else if (fast_fail[i])
			begin
				clean_q[i] <= 40'h0000000000;
				if (64'(fail_acc_q[i]) >= 64'(DISQ_CYC))
					disq_q[i] <= 1'b1; // [R11]
				else
					fail_acc_q[i] <= fail_acc_q[i] + 40'h0000000001; // [R12]
			end
			else if (64'(clean_q[i]) >= 64'(REQ_CYC))
			begin
				disq_q[i]     <= 1'b0; // [R13]
				fail_acc_q[i] <= 40'h0000000000;
			end
			else
				clean_q[i] <= clean_q[i] + 40'h0000000001;
		end
	end

	// Disqualify status outputs; they never feed the mode.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			primary_disqualified   <= 1'b1;
			secondary_disqualified <= 1'b1;
		end
		else
		begin
			primary_disqualified   <= disq_q[0];
			secondary_disqualified <= disq_q[1];
		end
	end

	// Reference choice and automatic holdover from fast failures only.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			sel_q         <= 1'b0;
			hold_q        <= 1'b1;
			holdover      <= 1'b1;
			selected_rate <= rmpc_pkg::RMPC_RATE_NONE;
		end
		else
		begin
			sel_q         <= sel_lvl; // [R02]
			hold_q        <= fast_fail[sel_lvl]; // [R10] [R14] [R16]
			holdover      <= hold_q;
			selected_rate <= mon[sel_q].rate;
		end
	end

	// Count cycles since the last selected reference edge; that count at a
	// feedback edge is the phase of feedback behind reference.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			since_ref_q <= rmpc_pkg::PER_RST;
			meas_q      <= rmpc_pkg::PER_RST;
		end
		else
		begin
			if (ref_rise[sel_q]) // [R01]
				since_ref_q <= '0;
			else if (since_ref_q != '1)
				since_ref_q <= since_ref_q + 24'h000001;
			if (fb_rise)
				meas_q <= wrap_phase(since_ref_q, period[sel_q]);
		end
	end

	// Flag a remeasure on a switch, or on recovery when hitless return is high.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			remeasure_q <= 1'b0;
		else if (sel_q != sel_lvl)
			remeasure_q <= 1'b1; // [R17] [R24]
		else if (hold_q && !fast_fail[sel_q] && hms_lvl)
			remeasure_q <= 1'b1; // [R23]
		else if (fb_rise)
			remeasure_q <= 1'b0;
	end

	// Stored offset: captured on remeasure, kept on plain recovery, and
	// zeroed at once after a clear with wide bandwidth, or walked toward zero by the shorter way with narrow bandwidth.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			target_q  <= rmpc_pkg::PER_RST;
			slew_q    <= 32'h00000000;
			clr_low_q <= 1'b0;
		end
		else
		begin
			// A clear long enough to pass the synchroniser keeps the realignment going until zero.
			clr_low_q <= clr_lvl_n | (clr_low_q & (target_q != '0));
			slew_q    <= (slew_q == 32'(rmpc_pkg::SLEW_STEP_CYC - 1)) ? 32'h0 : slew_q + 32'h1;
			if ((clr_lvl_n || clr_low_q) && bw_lvl)
				target_q <= '0; // [R18] [R20]
			else if (clr_lvl_n || clr_low_q)
			begin
				// Narrow bandwidth: step toward alignment at about 488 us/s, eight times the 61 us/s slew limit.
				if (target_q != '0 && slew_q == 32'h0)
				begin
					if (target_q > (period[sel_q] >> 1))
						target_q <= (target_q + 24'h000001 >= period[sel_q]) ? '0
							: target_q + 24'h000001; // [R19]
					else
						target_q <= target_q - 24'h000001; // [R19]
				end
			end
			else if (remeasure_q && fb_rise && !hold_q)
				target_q <= wrap_phase(since_ref_q, period[sel_q]); // [R17]
			// Otherwise the stored value is kept across holdover. [R22]
		end
	end

	// Virtual reference: a delayed copy of the selected reference edge.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			vcnt_q            <= rmpc_pkg::PER_RST;
			virtual_reference <= 1'b0;
			stored_offset     <= rmpc_pkg::PER_RST;
		end
		else
		begin
			stored_offset     <= target_q;
			virtual_reference <= 1'b0;
			if (ref_rise[sel_q] && target_q == '0)
				virtual_reference <= 1'b1; // [R01]
			else if (ref_rise[sel_q])
				vcnt_q <= target_q;
			else if (vcnt_q != '0)
			begin
				vcnt_q <= vcnt_q - 24'h000001;
				if (vcnt_q == 24'h000001)
					virtual_reference <= 1'b1; // [R17]
			end
		end
	end

endmodule

// file: tb/rmpc_ref_model.sv
// Purpose: Two reference clock sources and the loop feedback clock.
// Assumes: A stopped reference pin is held low by its pull-down.
// Notes:   Reference period is 488.3 ns; feedback runs free at 80 ns.
`timescale 1ns/100ps
module rmpc_ref_model
(
	input  wire logic en_pri,
	input  wire logic en_sec,
	output logic      primary_reference,
	output logic      secondary_reference,
	output logic      feedback
);
	// Feedback clock runs free at the link rate.
	initial
	begin
		feedback = 1'h0;
		forever #40 feedback = ~feedback;
	end
	// Primary source; uneven halves keep the mean period near nominal.
	initial
	begin
		primary_reference = 1'h0;
		forever
		begin
			#244.1 primary_reference = en_pri;
			#244.2 primary_reference = 1'h0;
		end
	end
	// Secondary source, started out of phase with the primary.
	initial
	begin
		secondary_reference = 1'h0;
		#97;
		forever
		begin
			#244.1 secondary_reference = en_sec;
			#244.2 secondary_reference = 1'h0;
		end
	end
endmodule

// file: tb/rmpc_top_monitor.sv
// Purpose: Port-level assertions for the reference monitor and corrector.
// Assumes: One clock domain, clk_sys, with reset active high.
// Notes:   Pin effects lag by the synchroniser, so guards wait a few cycles.
`timescale 1ns/100ps
module rmpc_top_monitor
(
	input wire logic                  clk_sys,
	input wire logic                  reset,
	input wire logic                  primary_reference,
	input wire logic                  secondary_reference,
	input wire logic                  reference_choice,
	input wire logic                  range_limit_choice,
	input wire logic                  phase_offset_clear_n,
	input wire logic                  loop_bandwidth_choice,
	input wire logic                  hitless_return_enable,
	input wire logic                  feedback,
	input wire logic                  primary_fault,
	input wire logic                  secondary_fault,
	input wire logic                  primary_disqualified,
	input wire logic                  secondary_disqualified,
	input wire logic                  holdover,
	input wire logic                  virtual_reference,
	input wire rmpc_pkg::rmpc_rate_t  selected_rate,
	input wire logic [23:0]           stored_offset
);
	logic [23:0] prev_offset_q;
	wire  [23:0] step = stored_offset - prev_offset_q;
	wire         sel_fault = reference_choice ? secondary_fault : primary_fault;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Previous offset, used to bound each alignment step.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			prev_offset_q <= 24'h000000;
		else
			prev_offset_q <= stored_offset;
	end
	a_reset_state: assert property ($fell(reset) |-> primary_fault && secondary_fault
		&& primary_disqualified && secondary_disqualified && holdover && !virtual_reference
		&& stored_offset == 24'h000000 && selected_rate == rmpc_pkg::RMPC_RATE_NONE)
		else $error("outputs not at reset values");
	a_hold_needs_fault: assert property ($stable(reference_choice)[*8] ##0 holdover[*3]
		|-> sel_fault || $past(sel_fault)) else $error("holdover without fault");
	a_clean_normal: assert property ($stable(reference_choice)[*6]
		##0 ($stable(reference_choice) && !sel_fault)[*4] |-> !holdover)
		else $error("holdover with clean reference");
	a_vref_pulse: assert property (virtual_reference |=> !virtual_reference)
		else $error("virtual reference longer than one cycle");
	a_disq_pri_fault: assert property ($rose(primary_disqualified) |-> primary_fault)
		else $error("primary disqualified while not failing");
	a_disq_sec_fault: assert property ($rose(secondary_disqualified) |-> secondary_fault)
		else $error("secondary disqualified while not failing");
	a_clear_wide_zero: assert property ((!phase_offset_clear_n && loop_bandwidth_choice)[*8]
		|-> stored_offset == 24'h000000) else $error("offset kept during clear");
	a_clear_slew_step: assert property ((!phase_offset_clear_n && !loop_bandwidth_choice)[*8]
		|=> step inside {24'h000000, 24'h000001, 24'hFFFFFF})
		else $error("alignment step too large");
	c_hold_rise: cover property ($rose(holdover));
	c_disq_rise: cover property ($rose(primary_disqualified));
	c_disq_fall: cover property ($fell(primary_disqualified));
	c_slew: cover property ((!phase_offset_clear_n && !loop_bandwidth_choice)[*8]);
endmodule
bind rmpc_top rmpc_top_monitor u_mon (.clk_sys, .reset, .primary_reference,
	.secondary_reference, .reference_choice, .range_limit_choice, .phase_offset_clear_n,
	.loop_bandwidth_choice, .hitless_return_enable, .feedback, .primary_fault,
	.secondary_fault, .primary_disqualified, .secondary_disqualified, .holdover,
	.virtual_reference, .selected_rate, .stored_offset);

// file: tb/tb.sv
// Purpose: Self-checking bench for the reference monitor and corrector.
// Assumes: Shortened timer counts; references near 2.048 MHz.
// Notes:   Pins change 1 ns after the rising clock edge.
`timescale 1ns/100ps
module tb;
	logic                 clk_sys, reset, reference_choice, range_limit_choice;
	logic                 phase_offset_clear_n, loop_bandwidth_choice, hitless_return_enable;
	logic                 en_pri, en_sec;
	logic                 primary_reference, secondary_reference, feedback;
	logic                 primary_fault, secondary_fault, primary_disqualified;
	logic                 secondary_disqualified, holdover, virtual_reference;
	rmpc_pkg::rmpc_rate_t selected_rate;
	logic [23:0]          stored_offset, off0;
	int                   n_mismatch = 0, total_checks = 0, vcnt = 0, t;
	rmpc_top #(.DISQ_CYC(2000), .REQ_CYC(8000), .PRECISE_CYC(20000)) dut (.clk_sys, .reset,
		.primary_reference, .secondary_reference, .reference_choice, .range_limit_choice,
		.phase_offset_clear_n, .loop_bandwidth_choice, .hitless_return_enable, .feedback,
		.primary_fault, .secondary_fault, .primary_disqualified, .secondary_disqualified,
		.holdover, .virtual_reference, .selected_rate, .stored_offset);
	rmpc_ref_model src (.en_pri, .en_sec, .primary_reference, .secondary_reference, .feedback);
	// System clock at 125 MHz.
	initial
	begin
		clk_sys = 1'h0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Counts virtual reference pulses.
	always @(posedge clk_sys)
		if (virtual_reference === 1'h1)
			vcnt++;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Waits a bounded time for the loop to leave holdover.
	task automatic wait_normal(input int lim);
		for (t = 0; t < lim && holdover !== 1'h0; t++)
			cyc(1);
		check(holdover, 1'h0);
	endtask
	// Stops one source for n cycles, checks its fault and the mode, then restarts it.
	task automatic outage(input logic sec, input int n, input logic hold_exp);
		if (sec)
			en_sec = 1'h0;
		else
			en_pri = 1'h0;
		cyc(n);
		check(sec ? secondary_fault : primary_fault, 1'h1);
		check(holdover, hold_exp);
		en_sec = 1'h1;
		en_pri = 1'h1;
	endtask
	// Main sequence of tests.
	initial
	begin
		reset = 1'h1;
		en_pri = 1'h1;
		en_sec = 1'h1;
		reference_choice = 1'h0;
		range_limit_choice = 1'h0;
		phase_offset_clear_n = 1'h1;
		loop_bandwidth_choice = 1'h0;
		hitless_return_enable = 1'h0;
		cyc(10);
		reset = 1'h0;
		check({primary_fault, secondary_fault, holdover}, 3'h7);
		check({primary_disqualified, secondary_disqualified}, 2'h3);
		$display("Test 1 complete");
		wait_normal(16000);
		check(selected_rate, rmpc_pkg::RMPC_RATE_2M048);
		for (t = 0; t < 20000 && primary_disqualified !== 1'h0; t++)
			cyc(1);
		check({primary_disqualified, secondary_disqualified}, 2'h0);
		$display("Test 2 complete");
		vcnt = 0;
		cyc(6103);
		check(vcnt >= 98 && vcnt <= 102, 1'h1);
		$display("Test 3 complete");
		off0 = stored_offset;
		outage(1'h0, 1400, 1'h1);
		wait_normal(5000);
		cyc(200);
		check(primary_disqualified, 1'h0);
		check(stored_offset, off0);
		outage(1'h0, 1400, 1'h1);
		wait_normal(5000);
		check(primary_disqualified, 1'h1);
		check(secondary_disqualified, 1'h0);
		$display("Test 4 complete");
		hitless_return_enable = 1'h1;
		reference_choice = 1'h1;
		cyc(20);
		outage(1'h0, 1400, 1'h0);
		outage(1'h1, 400, 1'h1);
		wait_normal(5000);
		range_limit_choice = 1'h1;
		cyc(1000);
		check(holdover, 1'h0);
		$display("Test 5 complete");
		// Clear only well after the loop has settled back in normal operation.
		loop_bandwidth_choice = 1'h1;
		phase_offset_clear_n = 1'h0;
		cyc(20);
		check(stored_offset, 24'h000000);
		reference_choice = 1'h0;
		cyc(300);
		check(stored_offset, 24'h000000);
		phase_offset_clear_n = 1'h1;
		loop_bandwidth_choice = 1'h0;
		cyc(50);
		phase_offset_clear_n = 1'h0;
		cyc(3000);
		phase_offset_clear_n = 1'h1;
		cyc(100);
		$display("Test 6 complete");
		tally_and_finish();
	end
	// Watchdog cuts a hang short.
	initial
	begin
		#760000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
